// *** logic/psi5_cfg_regs.svh ***
// Function
// - Pulldown switches on after a detected sync pulse only when its enable bit is 1.
// - In daisy chain, pulldown needs no address, or run command plus address 001.
// - Latency bit 0 references sync pulse, 1 references the assigned slot.
// - Response length bit 0 gives 10-bit payload, 1 gives 8-bit payload.
// - Sync pulses are ignored during blanking, ended per the blanking select bit.
// - Error check bit 0 appends even parity, 1 appends a 3-bit CRC.
// - Baud bit 0 selects 125 kBaud, 1 selects 190.5 kBaud; receiver matches.
// - Mode field: 00 normal, 01 double rate, 10 16-bit split, 11 daisy chain.
// - Filter field 00 is 3-pole, 01 is 4-pole 400 Hz; 10 and 11 reserved.
// - A non-zero slot field is the start delay from sync in 0.5 us steps.
// - A zero slot field means default delay; a zero first slot is asynchronous when free running.
// - The second slot is used only in double rate and 16-bit modes.
// - Extension bit 0 sends init fields D27 to D32 as 0000.
// - User manufacturing data never steers sensing; it is reported only with 10-bit payloads.
// - The user configuration bytes are one-time storage reading all zeros until programmed.
// - With free running enabled, responses go out without waiting for sync pulses.
// - The controller programs and reads the user bytes with commands over the link.
`ifndef PSI5_CFG_REGS_SVH
`define PSI5_CFG_REGS_SVH

// Register offsets on the link command port.
`define CFG_OFF_MODE_FILTER_SLOT_HIGH 4'h6
`define CFG_OFF_SLOT_A_LOW 4'h7
`define CFG_OFF_SLOT_B_LOW 4'h8
`define CFG_OFF_INIT_EXT_DIRECTION_REVISION 4'h9
`define CFG_OFF_PRODUCTION_MONTH_YEAR 4'hA
`define CFG_OFF_USER_DATA_PRODUCTION_DAY 4'hB
`define CFG_ENTRIES 6
`define CFG_RESET 8'h00

// Field positions inside the bytes.
`define F_MODE_HI 7
`define F_MODE_LO 6
`define F_LOWPASS_HI 5
`define F_LOWPASS_LO 4
`define F_SLOTB_HI 3
`define F_SLOTB_LO 2
`define F_SLOTA_HI 1
`define F_SLOTA_LO 0
`define F_INIT_EXT 7
`define F_FREE_RUN 6
`define F_DIR_HI 5
`define F_DIR_LO 4
`define F_REV_HI 3
`define F_REV_LO 0
`define F_MONTH_HI 7
`define F_MONTH_LO 4
`define F_YEAR_HI 3
`define F_YEAR_LO 0
`define F_UD_HI 7
`define F_UD_LO 5
`define F_DAY_HI 4
`define F_DAY_LO 0

// Coded values.
`define CHAIN_FIRST_ADDR 3'h1
`define PAYLOAD_LONG 4'hA
`define PAYLOAD_SHORT 4'h8

// Timing.
`define CLK_PERIOD_NS 5
`define SLOT_UNIT_NS 500
`define SLOT_UNIT_CYCLES (`SLOT_UNIT_NS / `CLK_PERIOD_NS)
`define DEFAULT_SLOT_DELAY_NS 50000
`define MIN_BLANK_NS 40000

`endif

// *** logic/psi5_cfg_pkg.sv ***
package psi5_cfg_pkg;

  typedef enum logic [1:0] {
    st_load = 2'b01,
    st_run = 2'b10
  } load_state_t;

  typedef enum logic [1:0] {
    mode_normal = 2'h0,
    mode_double = 2'h1,
    mode_res16 = 2'h2,
    mode_daisy = 2'h3
  } trans_mode_t;

  // Loose configuration bits held outside the user bytes.
  typedef struct packed {
    logic sync_pulldown_enable;
    logic latency_select;
    logic response_length_select;
    logic sync_blanking_select;
    logic error_check_select;
    logic baud_select;
  } static_bits_t;

  typedef struct packed {
    static_bits_t bits;
    trans_mode_t transmission_mode_select;
    logic [1:0] lowpass_select;
    logic [9:0] first_slot_position;
    logic [9:0] second_slot_position;
    logic free_running_enable;
    logic init_phase2_extension;
    logic [1:0] direction;
    logic [3:0] revision;
    logic [3:0] month;
    logic [3:0] year;
    logic [4:0] day;
    logic [2:0] user_data;
  } cfg_t;

  typedef struct packed {
    logic write;
    logic [3:0] addr;
    logic [7:0] wdata;
  } cmd_t;

  typedef struct packed {
    logic addr_programmed;
    logic run_mode_received;
    logic [2:0] addr;
  } chain_t;

endpackage

// *** logic/otp_user_array.sv ***
`timescale 1ns/10ps
`include "psi5_cfg_regs.svh"

module otp_user_array
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Write side.
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wdata,
  // Read side.
  input wire logic rd_en,
  input wire logic [2:0] rd_idx,
  output logic [7:0] rdata
);

  // An unprogrammed part powers up with every fuse clear.
  logic [7:0] entry [`CFG_ENTRIES] = '{default: `CFG_RESET};

  // Fuse bits only ever go from 0 to 1, so a write ORs into the stored byte.
  // The fuses ignore the functional reset, so programmed bytes reach the next load.
  for (genvar i = 0; i < `CFG_ENTRIES; i++)
  begin : g_entry
    always_ff @(posedge clk)
    begin
      if (wr_en && wr_idx == 3'(i))
        entry[i] <= entry[i] | wdata;
    end
  end

  // Registered read; an index past the array reads as zero.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else if (rd_en)
      rdata <= (rd_idx < 3'(`CFG_ENTRIES)) ? entry[rd_idx] : 8'h00;
  end

endmodule

// *** logic/psi5_sensor_config_bank.sv ***
`timescale 1ns/10ps
`include "psi5_cfg_regs.svh"

module psi5_sensor_config_bank
#(
  parameter int DEFAULT_SLOT_DELAY_NS = `DEFAULT_SLOT_DELAY_NS,
  parameter int MIN_BLANK_NS = `MIN_BLANK_NS
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Loose configuration bits.
  input wire psi5_cfg_pkg::static_bits_t static_bits,
  // Link command port.
  input wire logic cmd_valid,
  input wire psi5_cfg_pkg::cmd_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [7:0] rsp_data,
  // Sync and response events from the link engine.
  input wire logic sync_detected,
  input wire logic response_done,
  input wire psi5_cfg_pkg::chain_t chain,
  output logic sync_accepted,
  output logic sync_blanking,
  output logic sync_pulldown_on,
  // Init phase 2 extension data path.
  input wire logic [3:0] ext_field_in,
  output logic [3:0] ext_field_out,
  // Configuration seen by the rest of the sensor.
  output logic cfg_ready,
  output wire psi5_cfg_pkg::cfg_t cfg,
  output logic latency_from_slot,
  output logic [3:0] payload_bits,
  output logic crc_enable,
  output logic baud_fast,
  output logic lowpass_4pole,
  output logic free_running,
  output logic second_slot_used,
  output logic [16:0] first_slot_cycles,
  output logic [16:0] second_slot_cycles,
  output logic report_user_info
);

  // Least times round up to whole cycles.
  localparam logic [16:0] DEFAULT_SLOT_CYCLES =
    17'((DEFAULT_SLOT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  localparam logic [19:0] MIN_BLANK_CYCLES =
    20'((MIN_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);

  psi5_cfg_pkg::load_state_t state;
  logic [2:0] load_ptr;
  logic load_cap;
  logic [2:0] cap_idx;
  logic [7:0] shadow [`CFG_ENTRIES];
  psi5_cfg_pkg::static_bits_t bits_held;
  logic [7:0] mem_rdata;
  logic mem_rd_en;
  logic [2:0] mem_rd_idx;
  logic cmd_in_range;
  logic [2:0] cmd_idx;
  logic accept;
  logic pulldown_allowed;
  logic resp_seen;
  logic [19:0] blank_cnt;
  logic blank_end;

  // Command decode; refused while the load sequence owns the array.
  assign cmd_in_range = (cmd.addr >= `CFG_OFF_MODE_FILTER_SLOT_HIGH)
    && (cmd.addr <= `CFG_OFF_USER_DATA_PRODUCTION_DAY);
  assign cmd_idx = 3'(cmd.addr - `CFG_OFF_MODE_FILTER_SLOT_HIGH);
  assign cmd_ready = (state == psi5_cfg_pkg::st_run);
  assign accept = cmd_valid && cmd_ready;

  // The array read port is shared; loading has it until run begins.
  assign mem_rd_en = (state == psi5_cfg_pkg::st_load)
    ? (load_ptr < 3'(`CFG_ENTRIES)) : accept;
  assign mem_rd_idx = (state == psi5_cfg_pkg::st_load)
    ? load_ptr : (cmd_in_range ? cmd_idx : 3'h7);

  otp_user_array u_array
  (
    .clk(clk),
    .nrst(nrst),
    .wr_en(accept && cmd.write && cmd_in_range),
    .wr_idx(cmd_idx),
    .wdata(cmd.wdata),
    .rd_en(mem_rd_en),
    .rd_idx(mem_rd_idx),
    .rdata(mem_rdata)
  );

  // Load sequence walks the array once after reset, then stays in run.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state <= psi5_cfg_pkg::st_load;
      load_ptr <= 3'h0;
      load_cap <= 1'b0;
      cap_idx <= 3'h0;
    end
    else
    begin
      case (state)
        psi5_cfg_pkg::st_load:
        begin
          load_cap <= (load_ptr < 3'(`CFG_ENTRIES));
          cap_idx <= load_ptr;
          if (load_ptr < 3'(`CFG_ENTRIES))
            load_ptr <= load_ptr + 3'h1;
          else if (load_cap && cap_idx == 3'(`CFG_ENTRIES - 1))
            state <= psi5_cfg_pkg::st_run;
        end
        psi5_cfg_pkg::st_run:
        begin
          load_cap <= 1'b0;
        end
        default:
        begin
          state <= psi5_cfg_pkg::st_load;
        end
      endcase
    end
  end

  // Shadow bytes change only during the load; later programming waits for a reset.
  for (genvar i = 0; i < `CFG_ENTRIES; i++)
  begin : g_shadow
    always_ff @(posedge clk)
    begin
      if (!nrst)
        shadow[i] <= `CFG_RESET;
      else if (load_cap && cap_idx == 3'(i) && state == psi5_cfg_pkg::st_load)
        shadow[i] <= mem_rdata;
    end
  end

  // Loose bits are caught once, at the end of the load.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      bits_held <= '0;
    else if (state == psi5_cfg_pkg::st_load && load_ptr == 3'(`CFG_ENTRIES))
      bits_held <= static_bits;
  end

  // Field split of the shadow bytes.
  assign cfg.bits = bits_held;
  assign cfg.transmission_mode_select =
    psi5_cfg_pkg::trans_mode_t'(shadow[0][`F_MODE_HI:`F_MODE_LO]);
  assign cfg.lowpass_select = shadow[0][`F_LOWPASS_HI:`F_LOWPASS_LO];
  assign cfg.first_slot_position = {shadow[0][`F_SLOTA_HI:`F_SLOTA_LO], shadow[1]};
  assign cfg.second_slot_position = {shadow[0][`F_SLOTB_HI:`F_SLOTB_LO], shadow[2]};
  assign cfg.init_phase2_extension = shadow[3][`F_INIT_EXT];
  assign cfg.free_running_enable = shadow[3][`F_FREE_RUN];
  assign cfg.direction = shadow[3][`F_DIR_HI:`F_DIR_LO];
  assign cfg.revision = shadow[3][`F_REV_HI:`F_REV_LO];
  assign cfg.month = shadow[4][`F_MONTH_HI:`F_MONTH_LO];
  assign cfg.year = shadow[4][`F_YEAR_HI:`F_YEAR_LO];
  assign cfg.user_data = shadow[5][`F_UD_HI:`F_UD_LO];
  assign cfg.day = shadow[5][`F_DAY_HI:`F_DAY_LO];

  // A zero field falls back to the default delay; otherwise 0.5 us per step.
  function automatic logic [16:0] slot_cycles(input logic [9:0] pos);
    slot_cycles = (pos == 10'h000) ? DEFAULT_SLOT_CYCLES
      : 17'({7'h00, pos} * 17'(`SLOT_UNIT_CYCLES));
  endfunction

  // Decoded settings; registered so that downstream sees a clean copy.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cfg_ready <= 1'b0;
      latency_from_slot <= 1'b0;
      payload_bits <= `PAYLOAD_LONG;
      crc_enable <= 1'b0;
      baud_fast <= 1'b0;
      lowpass_4pole <= 1'b0;
      free_running <= 1'b0;
      second_slot_used <= 1'b0;
      first_slot_cycles <= 17'h00000;
      second_slot_cycles <= 17'h00000;
      report_user_info <= 1'b0;
    end
    else
    begin
      cfg_ready <= (state == psi5_cfg_pkg::st_run);
      latency_from_slot <= cfg.bits.latency_select;
      payload_bits <= cfg.bits.response_length_select
        ? `PAYLOAD_SHORT : `PAYLOAD_LONG;
      crc_enable <= cfg.bits.error_check_select;
      baud_fast <= cfg.bits.baud_select;
      // Reserved filter codes fall back to the 3-pole filter.
      lowpass_4pole <= (cfg.lowpass_select == 2'h1);
      free_running <= cfg.free_running_enable;
      first_slot_cycles <= (cfg.free_running_enable && cfg.first_slot_position == 10'h000)
        ? 17'h00000 : slot_cycles(cfg.first_slot_position);
      second_slot_used <= (cfg.transmission_mode_select == psi5_cfg_pkg::mode_double)
        || (cfg.transmission_mode_select == psi5_cfg_pkg::mode_res16);
      if ((cfg.transmission_mode_select == psi5_cfg_pkg::mode_double)
        || (cfg.transmission_mode_select == psi5_cfg_pkg::mode_res16))
        second_slot_cycles <= slot_cycles(cfg.second_slot_position);
      else
        second_slot_cycles <= 17'h00000;
      // Manufacturing bytes only leave the device; they feed no sensing path.
      report_user_info <= !cfg.bits.response_length_select;
    end
  end

  // Extension fields read as zero unless the extension bit is set.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      ext_field_out <= 4'h0;
    else
      ext_field_out <= cfg.init_phase2_extension ? ext_field_in : 4'h0;
  end

  // Command answer one cycle after acceptance; a write returns the old byte.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
    end
    else
    begin
      rsp_valid <= accept;
      rsp_error <= accept && !cmd_in_range;
    end
  end
  assign rsp_data = mem_rdata;

  // Free running transmission does not wait on sync pulses, so none is taken.
  assign sync_accepted = sync_detected && !sync_blanking && cfg_ready
    && !free_running;

  // Blanking: select 0 waits for both the minimum time and the response.
  assign blank_end = cfg.bits.sync_blanking_select
    ? response_done
    : ((resp_seen || response_done) && blank_cnt == 20'h00000);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sync_blanking <= 1'b0;
      resp_seen <= 1'b0;
      blank_cnt <= 20'h00000;
    end
    else if (sync_accepted)
    begin
      sync_blanking <= 1'b1;
      resp_seen <= 1'b0;
      blank_cnt <= MIN_BLANK_CYCLES - 20'h00001;
    end
    else if (sync_blanking)
    begin
      if (blank_cnt != 20'h00000)
        blank_cnt <= blank_cnt - 20'h00001;
      if (response_done)
        resp_seen <= 1'b1;
      if (blank_end)
        sync_blanking <= 1'b0;
    end
  end

  // Pulldown gate; in a daisy chain, once addressed, only the first node pulls down, after the run command.
  assign pulldown_allowed = cfg.bits.sync_pulldown_enable
    && ((cfg.transmission_mode_select != psi5_cfg_pkg::mode_daisy)
    || !chain.addr_programmed
    || (chain.run_mode_received && chain.addr == `CHAIN_FIRST_ADDR));

  // A new sync wins over a response end in the same cycle.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      sync_pulldown_on <= 1'b0;
    else if (!pulldown_allowed)
      sync_pulldown_on <= 1'b0;
    else if (sync_accepted)
      sync_pulldown_on <= 1'b1;
    else if (response_done)
      sync_pulldown_on <= 1'b0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  pulldown_follows_a: assert property (sync_accepted && pulldown_allowed |=> sync_pulldown_on)
    else $error("Pulldown did not follow an accepted sync.");
  pulldown_off_a: assert property (!cfg.bits.sync_pulldown_enable [*2] |-> !sync_pulldown_on)
    else $error("Pulldown on while disabled.");
  daisy_gate_a: assert property ((cfg.transmission_mode_select == psi5_cfg_pkg::mode_daisy
    && chain.addr_programmed && chain.addr != `CHAIN_FIRST_ADDR) [*2] |-> !sync_pulldown_on)
    else $error("Daisy node pulled down with wrong address.");
  payload_len_a: assert property (cfg_ready |-> payload_bits ==
    (cfg.bits.response_length_select ? 4'h8 : 4'hA))
    else $error("Payload length does not match selection.");
  blank_start_a: assert property (sync_accepted |=> sync_blanking ##0 !sync_accepted)
    else $error("Blanking did not start after sync.");
  blank_slot_end_a: assert property (sync_blanking && cfg.bits.sync_blanking_select
    && response_done && !sync_accepted |=> !sync_blanking)
    else $error("Slot blanking did not end with the response.");
  slot_scale_a: assert property (cfg_ready && cfg.first_slot_position != 10'h000
    |-> first_slot_cycles == 17'({7'h00, cfg.first_slot_position} * 17'h00064))
    else $error("Slot delay not in half microsecond steps.");
  slot_b_ignore_a: assert property (cfg_ready && !second_slot_used |-> second_slot_cycles == 17'h00000)
    else $error("Second slot used outside its modes.");
  ext_gate_a: assert property (!cfg.init_phase2_extension && $stable(cfg.init_phase2_extension)
    |=> ext_field_out == 4'h0)
    else $error("Extension field sent while disabled.");
  cfg_stable_a: assert property (cfg_ready && $past(cfg_ready) |-> $stable(cfg))
    else $error("Configuration changed during operation.");
  load_done_a: assert property ($rose(cmd_ready) |-> ##[1:2] cfg_ready)
    else $error("Load did not complete in time.");
  cmd_answer_a: assert property (accept |=> rsp_valid ##1 !rsp_valid || $past(accept))
    else $error("Command got no single answer.");

  daisy_sync_c: cover property (sync_accepted
    && cfg.transmission_mode_select == psi5_cfg_pkg::mode_daisy);
  write_c: cover property (accept && cmd.write && cmd_in_range);
  blank_cycle_c: cover property (sync_blanking ##1 !sync_blanking);

endmodule

// *** verification/psi5_link_ctrl_model.sv ***
`timescale 1ns/10ps

module psi5_link_ctrl_model
(
  // Clock.
  input wire logic clk,
  // Command port of the sensor.
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic [7:0] rsp_data,
  output logic cmd_valid,
  output psi5_cfg_pkg::cmd_t cmd,
  // Sync and response events.
  input wire logic sync_accepted,
  output logic sync_detected,
  output logic response_done
);
  // Idle at time zero so the sensor never sees an unknown request.
  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
    sync_detected = 1'b0;
    response_done = 1'b0;
  end

  // One command over the link, held until the edge that takes it.
  task automatic issue(input psi5_cfg_pkg::cmd_t c, output logic v, output logic e,
                       output logic [7:0] d);
    int n;
    begin
      n = 0;
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd = c;
      while (cmd_ready !== 1'b1 && n < 100)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      @(posedge clk);
      #1;
      // A released bus shows the inverse, so stale data can never look like a match.
      cmd_valid = 1'b0;
      cmd = ~c;
      v = rsp_valid;
      e = rsp_error;
      d = rsp_data;
    end
  endtask

  // One-cycle sync pulse; reports whether the sensor took it.
  task automatic sync_pulse(output logic a);
    begin
      @(posedge clk);
      #1;
      sync_detected = 1'b1;
      #1;
      a = sync_accepted;
      @(posedge clk);
      #1;
      sync_detected = 1'b0;
    end
  endtask

  // One-cycle end-of-response event from the transmitter.
  task automatic done_pulse();
    begin
      @(posedge clk);
      #1;
      response_done = 1'b1;
      @(posedge clk);
      #1;
      response_done = 1'b0;
    end
  endtask
endmodule

// *** verification/psi5_sensor_config_bank_tb.sv ***
`timescale 1ns/10ps
`include "psi5_cfg_regs.svh"

module psi5_sensor_config_bank_tb;
  localparam int DFLT_NS = 500;
  localparam int BLANK_NS = 200;
  localparam logic [31:0] DFLT_CYC = (DFLT_NS + 4) / 5;
  typedef struct packed {
    logic [5:0] bits;
    logic [3:0] pay;
    logic lat;
    logic crc;
    logic baud;
  } row_t;
  // Loose bits: pulldown, latency, length, blanking, error check, baud.
  row_t rows [4] = '{'{6'h00, 4'hA, 1'h0, 1'h0, 1'h0}, '{6'h3F, 4'h8, 1'h1, 1'h1, 1'h1},
                     '{6'h15, 4'hA, 1'h1, 1'h0, 1'h1}, '{6'h2A, 4'h8, 1'h0, 1'h1, 1'h0}};
  logic clk, nrst, cmd_valid, cmd_ready, rsp_valid, rsp_error, sync_detected;
  logic response_done, sync_accepted, sync_blanking, sync_pulldown_on, cfg_ready;
  logic latency_from_slot, crc_enable, baud_fast, lowpass_4pole, free_running;
  logic second_slot_used, report_user_info, a;
  logic [7:0] rsp_data;
  logic [3:0] ext_field_in, ext_field_out, payload_bits;
  logic [16:0] first_slot_cycles, second_slot_cycles;
  psi5_cfg_pkg::static_bits_t static_bits;
  psi5_cfg_pkg::cmd_t cmd;
  psi5_cfg_pkg::chain_t chain;
  psi5_cfg_pkg::cfg_t cfg;
  int failures = 0;
  int total_checks = 0;

  psi5_sensor_config_bank #(.DEFAULT_SLOT_DELAY_NS(DFLT_NS), .MIN_BLANK_NS(BLANK_NS)) dut
  (
    .clk(clk), .nrst(nrst), .static_bits(static_bits), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_data(rsp_data), .sync_detected(sync_detected), .response_done(response_done),
    .chain(chain), .sync_accepted(sync_accepted), .sync_blanking(sync_blanking),
    .sync_pulldown_on(sync_pulldown_on), .ext_field_in(ext_field_in),
    .ext_field_out(ext_field_out), .cfg_ready(cfg_ready), .cfg(cfg),
    .latency_from_slot(latency_from_slot), .payload_bits(payload_bits),
    .crc_enable(crc_enable), .baud_fast(baud_fast), .lowpass_4pole(lowpass_4pole),
    .free_running(free_running), .second_slot_used(second_slot_used),
    .first_slot_cycles(first_slot_cycles), .second_slot_cycles(second_slot_cycles),
    .report_user_info(report_user_info)
  );

  psi5_link_ctrl_model ctrl
  (
    .clk(clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd(cmd), .sync_accepted(sync_accepted),
    .sync_detected(sync_detected), .response_done(response_done)
  );

  // Free-running 200 MHz clock.
  always #2.5 clk = ~clk;

  // Compare one value; unknown bits never match.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      total_checks++;
      if (seen !== exp)
      begin
        failures++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task automatic results();
    begin
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // Reset for 12 cycles, try a sync while loading, then wait for the load to end.
  task automatic reset_dut(input logic [5:0] bits);
    int n;
    begin
      n = 0;
      static_bits = psi5_cfg_pkg::static_bits_t'(bits);
      nrst = 1'b0;
      repeat (12) @(posedge clk);
      #1;
      check(cmd_ready, 32'h0);
      check(payload_bits, 32'hA);
      nrst = 1'b1;
      ctrl.sync_pulse(a);
      check(a, 32'h0);
      while (cmd_ready !== 1'b1 && n < 20)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      check(cfg_ready, 32'h0);
      @(posedge clk);
      #1;
      check(cfg_ready, 32'h1);
    end
  endtask

  // One command with its expected answer.
  task automatic rw(input logic w, input logic [3:0] ad, input logic [7:0] wd,
                    input logic [7:0] exp_d, input logic exp_e);
    logic v, e;
    logic [7:0] d;
    begin
      ctrl.issue(psi5_cfg_pkg::cmd_t'({w, ad, wd}), v, e, d);
      check(v, 32'h1);
      check(e, {31'h0, exp_e});
      check(d, {24'h0, exp_d});
    end
  endtask

  // Sync, blanked second sync, end of response, then a fresh sync.
  task automatic sync_case(input logic [5:0] bits, input logic [4:0] ch, input logic pd,
                           input logic sel);
    begin
      chain = psi5_cfg_pkg::chain_t'(ch);
      reset_dut(bits);
      ctrl.sync_pulse(a);
      check(a, 32'h1);
      check(sync_blanking, 32'h1);
      check(sync_pulldown_on, {31'h0, pd});
      ctrl.sync_pulse(a);
      check(a, 32'h0);
      ctrl.done_pulse();
      check(sync_pulldown_on, 32'h0);
      check(sync_blanking, {31'h0, ~sel});
      repeat (40) @(posedge clk);
      #1;
      check(sync_blanking, 32'h0);
      ctrl.sync_pulse(a);
      check(a, 32'h1);
      $display("sync case %h done", bits);
    end
  endtask

  // Hang guard, well beyond the few hundred cycles the tests need.
  initial
  begin
    #100000;
    failures++;
    results();
  end

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    static_bits = '0;
    chain = psi5_cfg_pkg::chain_t'(5'h11);
    ext_field_in = 4'hF;
    // The controller leaves protection and slot choice to each row.
    for (int i = 0; i < 4; i++)
    begin
      reset_dut(rows[i].bits);
      check(payload_bits, {28'h0, rows[i].pay});
      check(crc_enable, {31'h0, rows[i].crc});
      check(baud_fast, {31'h0, rows[i].baud});
      check(latency_from_slot, {31'h0, rows[i].lat});
      check(report_user_info, {31'h0, rows[i].pay == 4'hA});
      check(lowpass_4pole, 32'h0);
      check(cfg.transmission_mode_select, 32'h0);
      check(cfg.first_slot_position, 32'h0);
      check(first_slot_cycles, DFLT_CYC);
      check(second_slot_used, 32'h0);
      check(second_slot_cycles, 32'h0);
      check(free_running, 32'h0);
      check(ext_field_out, 32'h0);
      $display("row %0d done", i);
    end
    // Unprogrammed bytes read zero; writes answer the old byte and accumulate.
    for (int ad = 6; ad < 12; ad++)
      rw(1'b0, ad[3:0], 8'h00, 8'h00, 1'b0);
    rw(1'b1, `CFG_OFF_MODE_FILTER_SLOT_HIGH, 8'h44, 8'h00, 1'b0);
    // Programmed bytes survive reset and load: double rate, second slot at 0x100.
    reset_dut(6'h00);
    check(cfg.transmission_mode_select, 32'h1);
    check(second_slot_used, 32'h1);
    check(second_slot_cycles, 32'h6400);
    check(first_slot_cycles, DFLT_CYC);
    $display("double rate load done");
    rw(1'b1, `CFG_OFF_MODE_FILTER_SLOT_HIGH, 8'h90, 8'h44, 1'b0);
    rw(1'b0, `CFG_OFF_MODE_FILTER_SLOT_HIGH, 8'h00, 8'hD4, 1'b0);
    rw(1'b1, `CFG_OFF_USER_DATA_PRODUCTION_DAY, 8'hFF, 8'h00, 1'b0);
    rw(1'b1, 4'h5, 8'hFF, 8'h00, 1'b1);
    rw(1'b0, 4'hC, 8'h00, 8'h00, 1'b1);
    rw(1'b0, `CFG_OFF_SLOT_A_LOW, 8'h00, 8'h00, 1'b0);
    rw(1'b0, `CFG_OFF_USER_DATA_PRODUCTION_DAY, 8'h00, 8'hFF, 1'b0);
    $display("register access done");
    // From here the node is a daisy chain member with the 4-pole filter.
    sync_case(6'h24, 5'h19, 1'b1, 1'b1);
    check(cfg.transmission_mode_select, 32'h3);
    check(lowpass_4pole, 32'h1);
    check(second_slot_used, 32'h0);
    check(second_slot_cycles, 32'h0);
    sync_case(6'h20, 5'h19, 1'b1, 1'b0);
    sync_case(6'h04, 5'h19, 1'b0, 1'b1);
    sync_case(6'h24, 5'h1A, 1'b0, 1'b1);
    sync_case(6'h24, 5'h11, 1'b0, 1'b1);
    sync_case(6'h24, 5'h00, 1'b1, 1'b1);
    // Free running with a zero first slot, and a reserved filter code.
    rw(1'b1, `CFG_OFF_INIT_EXT_DIRECTION_REVISION, 8'hC0, 8'h00, 1'b0);
    rw(1'b1, `CFG_OFF_MODE_FILTER_SLOT_HIGH, 8'h20, 8'hD4, 1'b0);
    reset_dut(6'h00);
    check(free_running, 32'h1);
    check(first_slot_cycles, 32'h0);
    check(lowpass_4pole, 32'h0);
    check(ext_field_out, 32'hF);
    ctrl.sync_pulse(a);
    check(a, 32'h0);
    check(sync_blanking, 32'h0);
    // A non-zero first slot counts in half microsecond steps even when free running.
    rw(1'b1, `CFG_OFF_SLOT_A_LOW, 8'h05, 8'h00, 1'b0);
    reset_dut(6'h00);
    check(first_slot_cycles, 32'h1F4);
    $display("programmed config done");
    results();
  end
endmodule
